// ==== logic/usr_fifo.sv ====
// byte fifo with single-entry overwrite mode for fifo-disabled operation
`timescale 1ns/1ps
module usr_fifo (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  input  wire logic                      i_single,
  input  wire logic                      i_flush,
  input  wire logic                      i_wr,
  input  wire logic [usr_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_rd,
  output logic      [usr_pkg::DATA_W-1:0] o_head,
  output logic                           o_empty,
  output logic                           o_full,
  output logic                           o_drop,
  output logic                           o_overwrite
);
  import usr_pkg::*;

  logic [DATA_W-1:0]  mem      [FIFO_DEPTH];
  logic [DATA_W-1:0]  next_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp;
  logic [FIFO_AW-1:0] rp;
  logic [CNT_W-1:0]   cnt;
  logic [FIFO_AW-1:0] next_wp;
  logic [FIFO_AW-1:0] next_rp;
  logic [CNT_W-1:0]   next_cnt;
  logic               do_rd;

  // capacity is one entry when the fifos are disabled
  assign o_full  = i_single ? (cnt != '0) : (cnt == CNT_W'(FIFO_DEPTH));
  assign o_empty = (cnt == '0);
  assign o_head  = mem[rp];
  assign do_rd   = i_rd && !o_empty;

  // pointer, count and storage next values
  always_comb begin
    next_mem    = mem;
    next_wp     = wp;
    next_rp     = rp;
    next_cnt    = cnt;
    o_drop      = 1'b0;
    o_overwrite = 1'b0;
    if (i_flush) begin
      next_wp  = '0;
      next_rp  = '0;
      next_cnt = '0;
    end else begin
      if (do_rd) begin
        next_rp  = rp + FIFO_AW'(1);
        next_cnt = cnt - CNT_W'(1);
      end
      if (i_wr) begin
        if (!o_full || do_rd) begin
          next_mem[wp] = i_wdata;
          next_wp      = wp + FIFO_AW'(1);
          next_cnt     = next_cnt + CNT_W'(1);
        end else if (i_single) begin
          next_mem[rp] = i_wdata;       // held byte replaced
          o_overwrite  = 1'b1;
        end else begin
          o_drop = 1'b1;                // stored entries kept
        end
      end
    end
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (i_ce) begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
      mem <= next_mem;
    end
  end
endmodule

// ==== logic/usr_pkg.sv ====
// constants shared by the shadow receive/transmit access block
package usr_pkg;
  // register addresses on the AXI4-Lite map
  localparam logic [31:0] SHADOW_2_ADDR  = 32'h5000_1138;
  localparam logic [31:0] SHADOW_3_ADDR  = 32'h5000_113c;
  localparam logic [31:0] SHADOW_STRIDE  = 32'h0000_0004;
  localparam logic [31:0] SHADOW_BASE    = SHADOW_2_ADDR - (SHADOW_STRIDE << 1);
  localparam logic [31:0] SHADOW_COUNT   = 32'h0000_0010;
  localparam logic [31:0] SHADOW_SPAN    = SHADOW_COUNT * SHADOW_STRIDE;
  localparam logic [31:0] CTRL_ADDR      = 32'h5000_1170;
  localparam logic [31:0] STAT_ADDR      = 32'h5000_1174;
  localparam logic [31:0] IRQ_STAT_ADDR  = 32'h5000_1178;
  localparam logic [31:0] IRQ_MASK_ADDR  = 32'h5000_117c;

  // field positions
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_BIT      = 1;
  localparam int STAT_DR_BIT      = 0;
  localparam int STAT_TX_HOLDING_EMPTY_FLAG_BIT    = 5;
  localparam int EV_RX_OVERRUN    = 0;
  localparam int EV_TX_DROP       = 1;
  localparam int EV_RX_AVAIL      = 2;
  localparam int EV_TX_EMPTY      = 3;
  localparam int EV_W             = 4;
  localparam int CTRL_W           = 2;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST     = 2'h0;
  localparam logic [EV_W-1:0]   IRQ_STAT_RST = 4'h0;
  localparam logic [EV_W-1:0]   IRQ_MASK_RST = 4'h0;

  // data path and fifo sizes
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int CNT_W      = 5;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus channel states
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } usr_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } usr_rd_state_t;
endpackage

// ==== logic/usr_shadow_top.sv ====
// shadow receive-buffer / transmit-holding access block with AXI4-Lite slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module usr_shadow_top (
  input  wire logic                      I_REF_CLK,
  input  wire logic                      I_RESET_N,
  input  wire logic                      I_CE,
  // AXI4-Lite slave
  input  wire logic [31:0]               I_AWADDR,
  input  wire logic                      I_AWVALID,
  output logic                           O_AWREADY,
  input  wire logic [31:0]               I_WDATA,
  input  wire logic [3:0]                I_WSTRB,
  input  wire logic                      I_WVALID,
  output logic                           O_WREADY,
  output logic [1:0]                     O_BRESP,
  output logic                           O_BVALID,
  input  wire logic                      I_BREADY,
  input  wire logic [31:0]               I_ARADDR,
  input  wire logic                      I_ARVALID,
  output logic                           O_ARREADY,
  output logic [31:0]                    O_RDATA,
  output logic [1:0]                     O_RRESP,
  output logic                           O_RVALID,
  input  wire logic                      I_RREADY,
  // received bytes from the normal and infrared receive shifters
  input  wire logic                      I_RX_SIN_VALID,
  input  wire logic [usr_pkg::DATA_W-1:0] I_RX_SIN_DATA,
  input  wire logic                      I_RX_SIR_VALID,
  input  wire logic [usr_pkg::DATA_W-1:0] I_RX_SIR_DATA,
  // bytes to the normal and infrared transmit shifters
  output logic                           O_TX_SOUT_VALID,
  output logic                           O_TX_SIR_VALID,
  output logic [usr_pkg::DATA_W-1:0]     O_TX_DATA,
  input  wire logic                      I_TX_READY,
  // status towards line status and interrupt logic
  output logic                           O_DATA_READY,
  output logic                           O_TX_HOLD_EMPTY,
  output logic                           O_RX_OVERRUN,
  output logic                           O_FIFO_ENABLE,
  output logic                           O_IR_MODE,
  output logic                           O_IRQ
);
  import usr_pkg::*;

  logic                rst_meta;
  logic                rst_n;
  usr_wr_state_t       wr_state;
  usr_wr_state_t       next_wr_state;
  usr_rd_state_t       rd_state;
  usr_rd_state_t       next_rd_state;
  logic                aw_held;
  logic [31:0]         aw_addr;
  logic                w_held;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                next_aw_held;
  logic [31:0]         next_aw_addr;
  logic                next_w_held;
  logic [31:0]         next_w_data;
  logic [3:0]          next_w_strb;
  logic [1:0]          next_bresp;
  logic [31:0]         next_rdata;
  logic [1:0]          next_rresp;
  logic [CTRL_W-1:0]   ctrl;
  logic [CTRL_W-1:0]   next_ctrl;
  logic [EV_W-1:0]     irq_stat;
  logic [EV_W-1:0]     irq_mask;
  logic [EV_W-1:0]     next_irq_stat;
  logic [EV_W-1:0]     next_irq_mask;
  logic [EV_W-1:0]     irq_clr;
  logic [EV_W-1:0]     events;
  logic                tx_empty_d;
  logic                tx_sout_v;
  logic                tx_sir_v;
  logic [DATA_W-1:0]   tx_data;
  logic                next_tx_sout_v;
  logic                next_tx_sir_v;
  logic [DATA_W-1:0]   next_tx_data;
  logic                wr_fire;
  logic                rd_fire;
  logic                wr_shadow;
  logic                rd_shadow;
  logic                flush;
  logic                rx_in_v;
  logic [DATA_W-1:0]   rx_in_d;
  logic [DATA_W-1:0]   rx_head;
  logic                rx_empty;
  logic                rx_drop;
  logic                rx_ovw;
  logic [DATA_W-1:0]   tx_head;
  logic                tx_empty;
  logic                tx_drop;
  logic                tx_pop;

  // reset release through two flip-flops
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // address decode: sixteen word aliases, upper address bits must match
  function automatic logic in_shadow(input logic [31:0] a);
    logic [31:0] off;
    off = a - SHADOW_BASE;
    in_shadow = (a >= SHADOW_BASE) && (off < SHADOW_SPAN);
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'b00};
    mapped = in_shadow(w) || (w == CTRL_ADDR) || (w == STAT_ADDR) ||
             (w == IRQ_STAT_ADDR) || (w == IRQ_MASK_ADDR);
  endfunction

  assign wr_fire   = (wr_state == WR_COLLECT) && aw_held && w_held;
  assign rd_fire   = I_ARVALID && O_ARREADY;
  assign wr_shadow = wr_fire && in_shadow({aw_addr[31:2], 2'b00}) && w_strb[0];
  assign rd_shadow = rd_fire && in_shadow({I_ARADDR[31:2], 2'b00});

  // receive source chosen by infrared mode
  assign rx_in_v = ctrl[CTRL_IR_BIT] ? I_RX_SIR_VALID : I_RX_SIN_VALID;
  assign rx_in_d = ctrl[CTRL_IR_BIT] ? I_RX_SIR_DATA : I_RX_SIN_DATA;

  // switching fifo mode empties both paths
  assign flush = wr_fire && (aw_addr[31:2] == CTRL_ADDR[31:2]) && w_strb[0] &&
                 (w_data[CTRL_FIFO_EN_BIT] != ctrl[CTRL_FIFO_EN_BIT]);

  // receive path: one held byte or sixteen-entry fifo
  usr_fifo u_rx_fifo (
    .i_clk       (I_REF_CLK),
    .i_rst_n     (rst_n),
    .i_ce        (I_CE),
    .i_single    (!ctrl[CTRL_FIFO_EN_BIT]),
    .i_flush     (flush),
    .i_wr        (rx_in_v),
    .i_wdata     (rx_in_d),
    .i_rd        (rd_shadow),
    .o_head      (rx_head),
    .o_empty     (rx_empty),
    .o_full      (),
    .o_drop      (rx_drop),
    .o_overwrite (rx_ovw)
  );

  // transmit path: one holding byte or sixteen-entry fifo
  usr_fifo u_tx_fifo (
    .i_clk       (I_REF_CLK),
    .i_rst_n     (rst_n),
    .i_ce        (I_CE),
    .i_single    (!ctrl[CTRL_FIFO_EN_BIT]),
    .i_flush     (flush),
    .i_wr        (wr_shadow),
    .i_wdata     (w_data[DATA_W-1:0]),
    .i_rd        (tx_pop),
    .o_head      (tx_head),
    .o_empty     (tx_empty),
    .o_full      (),
    .o_drop      (tx_drop),
    .o_overwrite ()
  );

  // write channel: collect address and data in either order, then respond
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_aw_addr  = aw_addr;
    next_w_held   = w_held;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bresp    = O_BRESP;
    if (I_AWVALID && O_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      next_w_held = 1'b1;
      next_w_data = I_WDATA;
      next_w_strb = I_WSTRB;
    end
    unique case (wr_state)
      WR_COLLECT: begin
        if (wr_fire) begin
          next_wr_state = WR_RESP;
          next_bresp    = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WR_RESP: begin
        if (I_BREADY) begin
          next_wr_state = WR_COLLECT;
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
        end
      end
    endcase
  end

  // read channel: shadow reads return and pop the receive head
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = O_RDATA;
    next_rresp    = O_RRESP;
    unique case (rd_state)
      RD_IDLE: begin
        if (rd_fire) begin
          next_rd_state = RD_RESP;
          next_rresp    = mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
          next_rdata    = '0;
          if (in_shadow({I_ARADDR[31:2], 2'b00})) begin
            next_rdata[DATA_W-1:0] = rx_head;
          end else if (I_ARADDR[31:2] == CTRL_ADDR[31:2]) begin
            next_rdata[CTRL_W-1:0] = ctrl;
          end else if (I_ARADDR[31:2] == STAT_ADDR[31:2]) begin
            next_rdata[STAT_DR_BIT]   = !rx_empty;
            next_rdata[STAT_TX_HOLDING_EMPTY_FLAG_BIT] = tx_empty;
          end else if (I_ARADDR[31:2] == IRQ_STAT_ADDR[31:2]) begin
            next_rdata[EV_W-1:0] = irq_stat;
          end else if (I_ARADDR[31:2] == IRQ_MASK_ADDR[31:2]) begin
            next_rdata[EV_W-1:0] = irq_mask;
          end
        end
      end
      RD_RESP: begin
        if (I_RREADY) begin
          next_rd_state = RD_IDLE;
        end
      end
    endcase
  end

  // software registers and sticky events, a set beats a clear
  always_comb begin
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    irq_clr       = '0;
    if (wr_fire && w_strb[0]) begin
      if (aw_addr[31:2] == CTRL_ADDR[31:2]) begin
        next_ctrl = w_data[CTRL_W-1:0];
      end
      if (aw_addr[31:2] == IRQ_STAT_ADDR[31:2]) begin
        irq_clr = w_data[EV_W-1:0];
      end
      if (aw_addr[31:2] == IRQ_MASK_ADDR[31:2]) begin
        next_irq_mask = w_data[EV_W-1:0];
      end
    end
    events                = '0;
    events[EV_RX_OVERRUN] = rx_drop || rx_ovw;
    events[EV_TX_DROP]    = tx_drop;
    events[EV_RX_AVAIL]   = rx_in_v;
    events[EV_TX_EMPTY]   = tx_empty && !tx_empty_d;
    next_irq_stat         = (irq_stat & ~irq_clr) | events;
  end

  // transmit output stage, routed to normal or infrared shifter
  always_comb begin
    next_tx_sout_v = tx_sout_v;
    next_tx_sir_v  = tx_sir_v;
    next_tx_data   = tx_data;
    tx_pop         = 1'b0;
    if ((!tx_sout_v && !tx_sir_v) || I_TX_READY) begin
      next_tx_sout_v = 1'b0;
      next_tx_sir_v  = 1'b0;
      if (!tx_empty) begin
        tx_pop         = 1'b1;
        next_tx_data   = tx_head;
        next_tx_sout_v = !ctrl[CTRL_IR_BIT];
        next_tx_sir_v  = ctrl[CTRL_IR_BIT];
      end
    end
  end

  // state registers
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_state        <= WR_COLLECT;
      rd_state        <= RD_IDLE;
      aw_held         <= 1'b0;
      aw_addr         <= '0;
      w_held          <= 1'b0;
      w_data          <= '0;
      w_strb          <= '0;
      O_AWREADY       <= 1'b0;
      O_WREADY        <= 1'b0;
      O_BVALID        <= 1'b0;
      O_BRESP         <= RESP_OKAY;
      O_ARREADY       <= 1'b0;
      O_RVALID        <= 1'b0;
      O_RDATA         <= '0;
      O_RRESP         <= RESP_OKAY;
      ctrl            <= CTRL_RST;
      irq_stat        <= IRQ_STAT_RST;
      irq_mask        <= IRQ_MASK_RST;
      tx_empty_d      <= 1'b1;
      tx_sout_v       <= 1'b0;
      tx_sir_v        <= 1'b0;
      tx_data         <= '0;
      O_DATA_READY    <= 1'b0;
      O_TX_HOLD_EMPTY <= 1'b1;
      O_RX_OVERRUN    <= 1'b0;
      O_IRQ           <= 1'b0;
    end else if (I_CE) begin
      wr_state        <= next_wr_state;
      rd_state        <= next_rd_state;
      aw_held         <= next_aw_held;
      aw_addr         <= next_aw_addr;
      w_held          <= next_w_held;
      w_data          <= next_w_data;
      w_strb          <= next_w_strb;
      O_AWREADY       <= !next_aw_held;
      O_WREADY        <= !next_w_held;
      O_BVALID        <= (next_wr_state == WR_RESP);
      O_BRESP         <= next_bresp;
      O_ARREADY       <= (next_rd_state == RD_IDLE);
      O_RVALID        <= (next_rd_state == RD_RESP);
      O_RDATA         <= next_rdata;
      O_RRESP         <= next_rresp;
      ctrl            <= next_ctrl;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      tx_empty_d      <= tx_empty;
      tx_sout_v       <= next_tx_sout_v;
      tx_sir_v        <= next_tx_sir_v;
      tx_data         <= next_tx_data;
      O_DATA_READY    <= !rx_empty;
      O_TX_HOLD_EMPTY <= tx_empty;
      O_RX_OVERRUN    <= events[EV_RX_OVERRUN];
      O_IRQ           <= |(next_irq_stat & next_irq_mask);
    end
  end

  // shifter-facing copies of the stage and mode
  assign O_TX_SOUT_VALID = tx_sout_v;
  assign O_TX_SIR_VALID  = tx_sir_v;
  assign O_TX_DATA       = tx_data;
  assign O_FIFO_ENABLE   = ctrl[CTRL_FIFO_EN_BIT];
  assign O_IR_MODE       = ctrl[CTRL_IR_BIT];
endmodule

// ==== tb/tb_uart_shadow_rx_tx_buffer_alias.sv ====
// self-checking bench for the shadow receive/transmit access block
`timescale 1ns/1ps
module tb_uart_shadow_rx_tx_buffer_alias;
  import usr_pkg::*;
  logic        I_REF_CLK, I_RESET_N, I_CE, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [31:0] I_AWADDR, I_WDATA, I_ARADDR, O_RDATA, d;
  logic [3:0]  I_WSTRB;
  logic [1:0]  O_BRESP, O_RRESP, r;
  logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, I_RX_SIN_VALID, I_RX_SIR_VALID;
  logic [7:0]  I_RX_SIN_DATA, I_RX_SIR_DATA, O_TX_DATA, b;
  logic        O_TX_SOUT_VALID, O_TX_SIR_VALID, I_TX_READY, O_DATA_READY, O_TX_HOLD_EMPTY;
  logic        O_RX_OVERRUN, O_FIFO_ENABLE, O_IR_MODE, O_IRQ, hold, slow;
  int          err_count, total_checks, fifo, irm, ovr, ovn, rxm[$], txm[$];

  usr_shadow_top i_usr_shadow_top (.I_REF_CLK, .I_RESET_N, .I_CE, .I_AWADDR, .I_AWVALID,
    .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY,
    .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY,
    .I_RX_SIN_VALID, .I_RX_SIN_DATA, .I_RX_SIR_VALID, .I_RX_SIR_DATA, .O_TX_SOUT_VALID,
    .O_TX_SIR_VALID, .O_TX_DATA, .I_TX_READY, .O_DATA_READY, .O_TX_HOLD_EMPTY,
    .O_RX_OVERRUN, .O_FIFO_ENABLE, .O_IR_MODE, .O_IRQ);
  usr_serial_model i_usr_serial_model (.i_clk(I_REF_CLK), .i_hold(hold), .i_slow(slow),
    .i_sout_valid(O_TX_SOUT_VALID), .i_sir_valid(O_TX_SIR_VALID), .i_tx_data(O_TX_DATA),
    .o_tx_ready(I_TX_READY), .o_sin_valid(I_RX_SIN_VALID), .o_sin_data(I_RX_SIN_DATA),
    .o_sir_valid(I_RX_SIR_VALID), .o_sir_data(I_RX_SIR_DATA));

  // 250 MHz clock
  initial begin
    I_REF_CLK = 1'b0;
    forever #2 I_REF_CLK = ~I_REF_CLK;
  end
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge I_REF_CLK);
    err_count++;
    stop_test();
  end

  // overrun pulses seen on the status output
  always @(posedge I_REF_CLK) if (O_RX_OVERRUN === 1'b1) ovn <= ovn + 1;
  // verdict and end of run
  task automatic stop_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] dt);
    bit ta, tw;
    @(posedge I_REF_CLK);
    I_AWADDR <= a;
    I_WDATA <= dt;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(posedge I_REF_CLK);
      if (I_AWVALID && O_AWREADY) begin
        ta = 1;
        I_AWVALID <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        tw = 1;
        I_WVALID <= 1'b0;
      end
    end
    while (!O_BVALID) @(posedge I_REF_CLK);
    r = O_BRESP;
    I_BREADY <= 1'b0;
  endtask
  // bus read into d and r
  task automatic rd(input logic [31:0] a);
    @(posedge I_REF_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do @(posedge I_REF_CLK); while (!O_ARREADY);
    I_ARVALID <= 1'b0;
    do @(posedge I_REF_CLK); while (!O_RVALID);
    d = O_RDATA;
    r = O_RRESP;
    I_RREADY <= 1'b0;
  endtask
  // received byte through the partner, mirrored in the receive model
  task automatic rx(input bit ir, input logic [7:0] v);
    i_usr_serial_model.send(ir, v);
    if (ir == irm) begin
      if (rxm.size() == (fifo ? FIFO_DEPTH : 1)) begin
        ovr = 1;
        if (!fifo) rxm[0] = v;
      end else rxm.push_back(v);
    end
  endtask
  // wait for the shifter side to take n bytes, then compare with the model
  task automatic drain(input int n);
    for (int k = 0; k < 4000 && i_usr_serial_model.cap.size() < n; k++) @(posedge I_REF_CLK);
    chk(i_usr_serial_model.cap.size(), n);
    foreach (txm[i]) chk(i_usr_serial_model.cap[i], txm[i]);
    i_usr_serial_model.cap.delete();
    txm.delete();
  endtask

  initial begin
    {I_RESET_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = '0;
    {I_AWADDR, I_WDATA, I_ARADDR} = '0;
    I_CE = 1'b1;
    I_WSTRB = 4'hf;
    hold = 1'b1;
    slow = 1'b0;
    {err_count, total_checks, fifo, irm, ovr} = '0;
    void'($urandom(40));
    repeat (8) @(posedge I_REF_CLK);
    I_RESET_N <= 1'b1;
    repeat (4) @(posedge I_REF_CLK);
    // reset values, unmapped place
    rd(CTRL_ADDR);
    chk(d, 32'h0);
    rd(STAT_ADDR);
    chk(d, 32'h20);
    chk(O_TX_HOLD_EMPTY, 1'b1);
    rd(SHADOW_2_ADDR);
    chk(d, 32'h0);
    rd(SHADOW_3_ADDR);
    chk(d, 32'h0);
    rd(32'h5000_1180);
    chk(r, RESP_SLVERR);
    wr(32'h5000_1180, 32'h1);
    chk(r, RESP_SLVERR);
    // write without byte lane 0 leaves the register alone
    I_WSTRB <= 4'he;
    wr(CTRL_ADDR, 32'h3);
    I_WSTRB <= 4'hf;
    rd(CTRL_ADDR);
    chk(d, 32'h0);
    // fifos off: second byte overwrites the first, overrun raises the interrupt
    wr(IRQ_MASK_ADDR, 32'h1);
    rx(0, 8'h11);
    rx(0, 8'h22);
    rd(IRQ_STAT_ADDR);
    chk(d, 32'h4 | ovr);
    chk(O_IRQ, 1'b1);
    rd(SHADOW_BASE);
    chk(d, rxm.pop_front());
    wr(IRQ_STAT_ADDR, 32'hf);
    rd(STAT_ADDR);
    chk(d, 32'h20);
    chk(O_IRQ, 1'b0);
    // infrared mode: normal input ignored
    wr(CTRL_ADDR, 32'h2);
    irm = 1;
    rx(0, 8'ha5);
    rx(1, 8'h5a);
    rd(STAT_ADDR);
    chk(d, 32'h21);
    rd(SHADOW_BASE + 32'd60);
    chk(d, rxm.pop_front());
    // fifos on: seventeenth byte lost, sixteen read back through every alias
    wr(CTRL_ADDR, 32'h1);
    wr(IRQ_STAT_ADDR, 32'hf);
    {fifo, irm, ovr} = {32'd1, 32'd0, 32'd0};
    for (int i = 0; i < 17; i++) rx(0, 8'($urandom));
    rd(IRQ_STAT_ADDR);
    chk(d, 32'h4 | ovr);
    chk(ovn, 32'd2);
    for (int i = 0; i < 16; i++) begin
      rd(SHADOW_BASE + 32'(4 * i));
      chk(d, rxm.pop_front());
    end
    rd(STAT_ADDR);
    chk(d, 32'h20);
    // fifos off, shifter stalled: third write overwrites the held byte
    wr(CTRL_ADDR, 32'h0);
    wr(IRQ_STAT_ADDR, 32'hf);
    fifo = 0;
    wr(SHADOW_2_ADDR, ($urandom & 32'hffff_ff00) | 32'h31);
    wr(SHADOW_3_ADDR, 32'h32);
    rd(STAT_ADDR);
    chk(d, 32'h00);
    chk(O_TX_HOLD_EMPTY, 1'b0);
    wr(SHADOW_2_ADDR, 32'h33);
    txm = '{32'h31, 32'h33};
    @(posedge I_REF_CLK);
    hold <= 1'b0;
    drain(2);
    // fifos on, infrared: stage plus sixteen accepted, eighteenth dropped
    wr(CTRL_ADDR, 32'h3);
    wr(IRQ_STAT_ADDR, 32'hf);
    @(posedge I_REF_CLK);
    hold <= 1'b1;
    slow <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      b = 8'($urandom);
      wr(SHADOW_BASE + 32'(4 * (i % 16)), {24'h0, b});
      if (i < 17) txm.push_back(256 + b);
    end
    rd(IRQ_STAT_ADDR);
    chk(d, 32'ha);
    chk(O_IRQ, 1'b0);
    rd(STAT_ADDR);
    chk(d, 32'h00);
    chk({O_IR_MODE, O_FIFO_ENABLE}, 2'h3);
    @(posedge I_REF_CLK);
    hold <= 1'b0;
    drain(17);
    stop_test();
  end
endmodule

// ==== tb/usr_serial_model.sv ====
// serial-side stand-in: supplies received bytes, takes transmit bytes
`timescale 1ns/1ps
module usr_serial_model (
  input  wire logic       i_clk,
  input  wire logic       i_hold,
  input  wire logic       i_slow,
  input  wire logic       i_sout_valid,
  input  wire logic       i_sir_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_sin_valid,
  output logic [7:0]      o_sin_data,
  output logic            o_sir_valid,
  output logic [7:0]      o_sir_data
);
  int cap[$];
  initial begin
    o_tx_ready = 1'b0;
    o_sin_valid = 1'b0;
    o_sir_valid = 1'b0;
    o_sin_data = 8'h00;
    o_sir_data = 8'hff;
  end
  // shifter readiness: stalled, random or prompt
  always @(posedge i_clk) o_tx_ready <= !i_hold && (!i_slow || 1'($urandom_range(1)));
  // take the byte at a ready edge, noting the infrared path in bit 8
  always @(posedge i_clk)
    if (o_tx_ready && (i_sout_valid || i_sir_valid)) begin
      cap.push_back({i_sir_valid, i_tx_data});
    end
  // one received byte, then the idle data lines show its inverse
  task automatic send(input bit ir, input logic [7:0] b);
    @(posedge i_clk);
    if (ir) begin
      o_sir_valid <= 1'b1;
      o_sir_data <= b;
    end else begin
      o_sin_valid <= 1'b1;
      o_sin_data <= b;
    end
    @(posedge i_clk);
    o_sin_valid <= 1'b0;
    o_sir_valid <= 1'b0;
    o_sin_data <= ~b;
    o_sir_data <= ~b;
  endtask
endmodule

// ==== tb/usr_shadow_properties.sv ====
// port-level checks for the shadow receive/transmit access block
`timescale 1ns/1ps
module usr_shadow_properties (
  input wire logic                       I_REF_CLK,
  input wire logic                       I_RESET_N,
  input wire logic                       I_AWVALID,
  input wire logic                       O_AWREADY,
  input wire logic                       I_WVALID,
  input wire logic                       O_WREADY,
  input wire logic                       O_BVALID,
  input wire logic                       I_BREADY,
  input wire logic                       I_ARVALID,
  input wire logic                       O_ARREADY,
  input wire logic                       O_RVALID,
  input wire logic                       I_RREADY,
  input wire logic [31:0]                O_RDATA,
  input wire logic                       I_RX_SIN_VALID,
  input wire logic                       I_RX_SIR_VALID,
  input wire logic                       O_TX_SOUT_VALID,
  input wire logic                       O_TX_SIR_VALID,
  input wire logic [usr_pkg::DATA_W-1:0] O_TX_DATA,
  input wire logic                       I_TX_READY,
  input wire logic                       O_DATA_READY,
  input wire logic                       O_RX_OVERRUN,
  input wire logic                       O_IR_MODE
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  // both write halves taken at one edge
  sequence s_wr_taken;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  // a byte offered to the normal transmit shifter and not yet taken
  sequence s_tx_waiting;
    O_TX_SOUT_VALID && !I_TX_READY;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] O_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read response missing");
  a_bresp_holds: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("write response dropped early");
  a_rdata_holds: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data not held");
  a_bus_busy: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write channel ready during response");
  a_tx_holds: assert property (s_tx_waiting |=> O_TX_SOUT_VALID && $stable(O_TX_DATA))
    else $error("transmit byte not held");
  a_tx_path_mode: assert property ((O_TX_SOUT_VALID || O_TX_SIR_VALID) |->
    (O_TX_SIR_VALID == O_IR_MODE) && (O_TX_SOUT_VALID != O_IR_MODE))
    else $error("transmit byte on wrong path");
  a_rx_ready: assert property (I_RX_SIN_VALID && !O_IR_MODE |=> ##[0:2] O_DATA_READY)
    else $error("data ready missing after arrival");
  a_overrun_cause: assert property (O_RX_OVERRUN |-> $past(I_RX_SIN_VALID) ||
    $past(I_RX_SIR_VALID) || $past(I_RX_SIN_VALID, 2) || $past(I_RX_SIR_VALID, 2))
    else $error("overrun without arrival");
endmodule

bind usr_shadow_top usr_shadow_properties i_usr_shadow_properties (.I_REF_CLK, .I_RESET_N,
  .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY,
  .O_RVALID, .I_RREADY, .O_RDATA, .I_RX_SIN_VALID, .I_RX_SIR_VALID, .O_TX_SOUT_VALID,
  .O_TX_SIR_VALID, .O_TX_DATA, .I_TX_READY, .O_DATA_READY, .O_RX_OVERRUN, .O_IR_MODE);
